/* logic/acd_pkg.sv */
// Shared constants and types for the storage command decoder
package acd_pkg;
   // Clock and activity stretch timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACT_TICK_NS = 1000;
   localparam int ACT_TICK_CYC = (ACT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] ACT_TICK_LAST = 7'(ACT_TICK_CYC - 1);
   localparam logic [7:0] ACT_HOLD_TICKS = 8'h32;
   // Cycles after reset release before the sideband strap is sampled
   localparam logic [1:0] STRAP_LAST = 2'h3;

   // General command opcodes
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_DSM = 8'h06;
   localparam logic [7:0] OP_RD_SECT = 8'h20;
   localparam logic [7:0] OP_RD_SECT_NR = 8'h21;
   localparam logic [7:0] OP_RD_SECT_EXT = 8'h24;
   localparam logic [7:0] OP_RD_DMA_EXT = 8'h25;
   localparam logic [7:0] OP_RD_NATIVE_EXT = 8'h27;
   localparam logic [7:0] OP_RD_LOG_EXT = 8'h2F;
   localparam logic [7:0] OP_WR_SECT = 8'h30;
   localparam logic [7:0] OP_WR_SECT_NR = 8'h31;
   localparam logic [7:0] OP_WR_SECT_EXT = 8'h34;
   localparam logic [7:0] OP_WR_DMA_EXT = 8'h35;
   localparam logic [7:0] OP_SET_MAX_EXT = 8'h37;
   localparam logic [7:0] OP_WR_DMA_FUA = 8'h3D;
   localparam logic [7:0] OP_WR_LOG_EXT = 8'h3F;
   localparam logic [7:0] OP_VERIFY = 8'h40;
   localparam logic [7:0] OP_VERIFY_NR = 8'h41;
   localparam logic [7:0] OP_VERIFY_EXT = 8'h42;
   localparam logic [7:0] OP_DIAG = 8'h90;
   localparam logic [7:0] OP_INIT_PARAMS = 8'h91;
   localparam logic [7:0] OP_MICROCODE = 8'h92;
   localparam logic [7:0] OP_STBY_IMM_ALT = 8'h94;
   localparam logic [7:0] OP_IDLE_IMM_ALT = 8'h95;
   localparam logic [7:0] OP_STBY_ALT = 8'h96;
   localparam logic [7:0] OP_IDLE_ALT = 8'h97;
   localparam logic [7:0] OP_PWR_MODE_ALT = 8'h98;
   localparam logic [7:0] OP_SLEEP_ALT = 8'h99;
   localparam logic [7:0] OP_HEALTH = 8'hB0;
   localparam logic [7:0] OP_RD_MULT = 8'hC4;
   localparam logic [7:0] OP_WR_MULT = 8'hC5;
   localparam logic [7:0] OP_SET_MULT = 8'hC6;
   localparam logic [7:0] OP_RD_DMA = 8'hC8;
   localparam logic [7:0] OP_WR_DMA = 8'hCA;
   localparam logic [7:0] OP_STBY_IMM = 8'hE0;
   localparam logic [7:0] OP_IDLE_IMM = 8'hE1;
   localparam logic [7:0] OP_STBY = 8'hE2;
   localparam logic [7:0] OP_IDLE = 8'hE3;
   localparam logic [7:0] OP_RD_BUF = 8'hE4;
   localparam logic [7:0] OP_PWR_MODE = 8'hE5;
   localparam logic [7:0] OP_SLEEP = 8'hE6;
   localparam logic [7:0] OP_FLUSH = 8'hE7;
   localparam logic [7:0] OP_WR_BUF = 8'hE8;
   localparam logic [7:0] OP_FLUSH_EXT = 8'hEA;
   localparam logic [7:0] OP_IDENTIFY = 8'hEC;
   localparam logic [7:0] OP_SET_FEAT = 8'hEF;
   localparam logic [7:0] OP_SEC_SET_PWD = 8'hF1;
   localparam logic [7:0] OP_SEC_UNLOCK = 8'hF2;
   localparam logic [7:0] OP_SEC_ERASE_PREP = 8'hF3;
   localparam logic [7:0] OP_SEC_ERASE = 8'hF4;
   localparam logic [7:0] OP_SEC_FREEZE = 8'hF5;
   localparam logic [7:0] OP_SEC_DIS_PWD = 8'hF6;
   localparam logic [7:0] OP_RD_NATIVE = 8'hF8;
   localparam logic [7:0] OP_SET_MAX = 8'hF9;

   // Health-monitoring subcommands carried in the features byte
   localparam logic [7:0] HM_RD_DATA = 8'hD0;
   localparam logic [7:0] HM_RD_THRESH = 8'hD1;
   localparam logic [7:0] HM_AUTOSAVE = 8'hD2;
   localparam logic [7:0] HM_SAVE = 8'hD3;
   localparam logic [7:0] HM_OFFLINE = 8'hD4;
   localparam logic [7:0] HM_RD_LOG = 8'hD5;
   localparam logic [7:0] HM_WR_LOG = 8'hD6;
   localparam logic [7:0] HM_ENABLE = 8'hD8;
   localparam logic [7:0] HM_DISABLE = 8'hD9;
   localparam logic [7:0] HM_STATUS = 8'hDA;

   // Capacity-limit subcommands carried in the features byte
   localparam logic [7:0] SM_ADDR = 8'h00;
   localparam logic [7:0] SM_SET_PWD = 8'h01;
   localparam logic [7:0] SM_LOCK = 8'h02;
   localparam logic [7:0] SM_UNLOCK = 8'h03;
   localparam logic [7:0] SM_FREEZE = 8'h04;

   // Transfer protocol classes
   typedef enum logic [2:0] {
      PROTO_NONDATA = 3'b000,
      PROTO_PIO_IN = 3'b001,
      PROTO_PIO_OUT = 3'b010,
      PROTO_DMA = 3'b011,
      PROTO_DIAG = 3'b100,
      PROTO_ABORT = 3'b101
   } acd_proto_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ANSWER = 2'b01,
      ST_BUSY = 2'b10
   } acd_state_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] features;
   } acd_cmd_t;

   typedef struct packed {
      acd_proto_t proto;
      logic [7:0] opcode;
      logic error;
   } acd_resp_t;

   // Decoder state
   typedef struct packed {
      acd_state_t st;
      acd_resp_t resp;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic stagger_dis;
   } acd_main_t;

   // Activity stretcher state
   typedef struct packed {
      logic [6:0] div;
      logic [7:0] hold;
   } acd_act_t;

   // Synchroniser state
   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] sync;
   } acd_sync_t;
endpackage

/* logic/acd_sync2.sv */
// Two-flop synchroniser for the two sideband input pins
`timescale 1ns/1ns
module acd_sync2
   import acd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Asynchronous pins and synchronised copies
   input wire logic [1:0] pin_in,
   output logic [1:0] pin_sync
);
   acd_sync_t s_q;
   acd_sync_t s_d;

   // First stage feeds only the second stage
   always_comb begin
      s_d.meta = pin_in;
      s_d.sync = s_q.meta;
   end

   // Pins idle high (pulled up), so reset to ones
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{meta: 2'h3, sync: 2'h3};
      end else begin
         s_q <= s_d;
      end
   end

   assign pin_sync = s_q.sync;
endmodule

/* logic/acd_activity.sv */
// Activity stretcher: keeps the activity indication visible after short commands
`timescale 1ns/1ns
module acd_activity
   import acd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Busy level in, stretched activity out
   input wire logic busy,
   output logic act_on
);
   acd_act_t a_q;
   acd_act_t a_d;
   logic tick;

   // Microsecond tick from a free-running divider
   assign tick = (a_q.div == ACT_TICK_LAST);

   // Reload the hold count while busy, count it down on ticks
   always_comb begin
      a_d = a_q;
      a_d.div = tick ? 7'h00 : a_q.div + 7'h01;
      if (busy) begin
         a_d.hold = ACT_HOLD_TICKS;
      end else if (tick && a_q.hold != 8'h00) begin
         a_d.hold = a_q.hold - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         a_q <= '0;
      end else begin
         a_q <= a_d;
      end
   end

   assign act_on = busy | (a_q.hold != 8'h00);
endmodule

/* logic/acd_decoder.sv */
// Storage command decoder: opcode classification, sideband and two-wire pins
// Behaviour
// - Opcode 90h runs as a device-diagnostic class command.
// - Cache flush E7h and EAh complete with no data phase.
// - Identify ECh returns data by PIO data-in.
// - Reads C8h and 25h move data to the host by DMA.
// - Writes CAh, 35h and 3Dh move data by DMA.
// - 20h, 21h, 24h, C4h and 2Fh are PIO data-in.
// - 30h, 31h, 34h, C5h and 3Fh are PIO data-out.
// - Verify 40h, 41h and 42h are non-data.
// - EFh, C6h, 91h and 00h are non-data.
// - Buffer read E4h is PIO data-in, buffer write E8h PIO data-out.
// - 06h takes a host-to-device payload; 92h is recognised.
// - Power query E5h/98h and idle E3h/97h are non-data.
// - E1h/95h, E6h/99h, E2h/96h, E0h/94h are non-data.
// - Security F1h, F2h, F4h, F6h take a PIO data-out payload.
// - Security F3h and F5h are non-data.
// - B0h reads are PIO data-in; other health operations except log write non-data.
// - B0h log write takes its payload by PIO data-out.
// - F8h, 27h and 37h capacity commands and the F9h address set are non-data.
// - F9h password and unlock are PIO data-out; lock, freeze non-data.
// - One sideband pin shows activity and carries stagger-disable from host.
// - Two-wire clock and data pins stay unused and inactive.
`timescale 1ns/1ns
module acd_decoder
   import acd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Command request
   input wire logic cmd_valid,
   input wire acd_cmd_t cmd,
   output logic cmd_ready,
   // Classification answer
   output logic resp_valid,
   output acd_resp_t resp,
   // Back end reports command completion
   input wire logic cmd_done,
   // Activity / stagger-disable sideband pin
   input wire logic activity_or_stagger_disable_in,
   output logic activity_or_stagger_disable_out,
   output logic activity_or_stagger_disable_oe_n,
   output logic stagger_disable,
   // Deep sleep request pin
   input wire logic deep_sleep_request_in,
   output logic deep_sleep_request,
   // Two-wire pins, never driven
   output logic twi_clk_out,
   output logic twi_clk_oe_n,
   output logic twi_data_out,
   output logic twi_data_oe_n
);
   acd_main_t m_q;
   acd_main_t m_d;
   logic [1:0] pins_sync;
   logic act_on;
   logic take;

   // Maps opcode and features to a transfer protocol class
   function automatic acd_proto_t classify(input acd_cmd_t c);
      acd_proto_t p;
      p = PROTO_ABORT;
      unique case (c.opcode)
         OP_DIAG: p = PROTO_DIAG;
         OP_FLUSH, OP_FLUSH_EXT: p = PROTO_NONDATA;
         OP_IDENTIFY: p = PROTO_PIO_IN;
         OP_RD_DMA, OP_RD_DMA_EXT: p = PROTO_DMA;
         OP_WR_DMA, OP_WR_DMA_EXT, OP_WR_DMA_FUA: p = PROTO_DMA;
         OP_RD_SECT, OP_RD_SECT_NR, OP_RD_SECT_EXT, OP_RD_MULT,
         OP_RD_LOG_EXT: p = PROTO_PIO_IN;
         OP_WR_SECT, OP_WR_SECT_NR, OP_WR_SECT_EXT, OP_WR_MULT,
         OP_WR_LOG_EXT: p = PROTO_PIO_OUT;
         OP_VERIFY, OP_VERIFY_NR, OP_VERIFY_EXT: p = PROTO_NONDATA;
         OP_SET_FEAT, OP_SET_MULT, OP_INIT_PARAMS, OP_NOP: p = PROTO_NONDATA;
         OP_RD_BUF: p = PROTO_PIO_IN;
         OP_WR_BUF: p = PROTO_PIO_OUT;
         OP_DSM, OP_MICROCODE: p = PROTO_PIO_OUT;
         OP_PWR_MODE, OP_PWR_MODE_ALT, OP_IDLE, OP_IDLE_ALT: p = PROTO_NONDATA;
         OP_IDLE_IMM, OP_IDLE_IMM_ALT, OP_SLEEP, OP_SLEEP_ALT, OP_STBY, OP_STBY_ALT,
         OP_STBY_IMM, OP_STBY_IMM_ALT: p = PROTO_NONDATA;
         OP_SEC_SET_PWD, OP_SEC_UNLOCK, OP_SEC_ERASE,
         OP_SEC_DIS_PWD: p = PROTO_PIO_OUT;
         OP_SEC_ERASE_PREP, OP_SEC_FREEZE: p = PROTO_NONDATA;
         OP_RD_NATIVE, OP_RD_NATIVE_EXT, OP_SET_MAX_EXT: p = PROTO_NONDATA;
         OP_HEALTH: begin
            // Subcommand comes from the features byte
            unique case (c.features)
               HM_RD_DATA, HM_RD_THRESH, HM_RD_LOG: p = PROTO_PIO_IN;
               HM_AUTOSAVE, HM_SAVE, HM_OFFLINE, HM_ENABLE, HM_DISABLE,
               HM_STATUS: p = PROTO_NONDATA;
               HM_WR_LOG: p = PROTO_PIO_OUT;
               default: p = PROTO_ABORT;
            endcase
         end
         OP_SET_MAX: begin
            unique case (c.features)
               SM_ADDR, SM_LOCK, SM_FREEZE: p = PROTO_NONDATA;
               SM_SET_PWD, SM_UNLOCK: p = PROTO_PIO_OUT;
               default: p = PROTO_ABORT;
            endcase
         end
         default: p = PROTO_ABORT;
      endcase
      return p;
   endfunction

   // Sideband pins pass two flops before use
   acd_sync2 u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin_in({deep_sleep_request_in, activity_or_stagger_disable_in}),
      .pin_sync(pins_sync)
   );

   // Activity stretched so that short commands stay visible
   acd_activity u_act (
      .clk(clk),
      .reset_n(reset_n),
      .busy(m_q.st != ST_IDLE),
      .act_on(act_on)
   );

   assign cmd_ready = (m_q.st == ST_IDLE);
   assign take = cmd_valid & cmd_ready;

   // Next-state logic: take, answer, wait for completion; strap capture
   always_comb begin
      m_d = m_q;
      unique case (m_q.st)
         ST_IDLE: begin
            if (take) begin
               m_d.st = ST_ANSWER;
               m_d.resp.proto = classify(cmd);
               m_d.resp.opcode = cmd.opcode;
               m_d.resp.error = (classify(cmd) == PROTO_ABORT);
            end
         end
         ST_ANSWER: begin
            // Aborted commands skip the data phase entirely
            m_d.st = m_q.resp.error ? ST_IDLE : ST_BUSY;
         end
         ST_BUSY: begin
            if (cmd_done) begin
               m_d.st = ST_IDLE;
            end
         end
         default: m_d.st = ST_IDLE;
      endcase
      // Host strap on the shared pin is read before the device drives it
      if (!m_q.strap_done) begin
         if (m_q.strap_cnt == STRAP_LAST) begin
            m_d.strap_done = 1'b1;
            m_d.stagger_dis = ~pins_sync[0];
         end else begin
            m_d.strap_cnt = m_q.strap_cnt + 2'h1;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         m_q <= '{st: ST_IDLE, resp: '{proto: PROTO_NONDATA, opcode: 8'h00, error: 1'b0},
                  strap_cnt: 2'h0, strap_done: 1'b0, stagger_dis: 1'b0};
      end else begin
         m_q <= m_d;
      end
   end

   // Answer outputs
   assign resp_valid = (m_q.st == ST_ANSWER);
   assign resp = m_q.resp;

   // Activity drives the shared pin low once the strap is captured
   assign activity_or_stagger_disable_out = 1'b0;
   assign activity_or_stagger_disable_oe_n = ~(m_q.strap_done & act_on);
   assign stagger_disable = m_q.stagger_dis;
   assign deep_sleep_request = ~pins_sync[1];

   // Two-wire pins are released at all times
   assign twi_clk_out = 1'b0;
   assign twi_clk_oe_n = 1'b1;
   assign twi_data_out = 1'b0;
   assign twi_data_oe_n = 1'b1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   property p_diag;
      take && cmd.opcode == OP_DIAG |=> resp_valid && resp.proto == PROTO_DIAG;
   endproperty
   a_diag: assert property (p_diag) else $error("diagnostic misclassified");

   property p_flush;
      take && (cmd.opcode == OP_FLUSH || cmd.opcode == OP_FLUSH_EXT)
         |=> resp.proto == PROTO_NONDATA && !resp.error;
   endproperty
   a_flush: assert property (p_flush) else $error("flush not non-data");

   property p_ident;
      take && cmd.opcode == OP_IDENTIFY |=> resp_valid ##0 resp.proto == PROTO_PIO_IN;
   endproperty
   a_ident: assert property (p_ident) else $error("identify not PIO in");

   property p_rd_dma;
      take && (cmd.opcode == OP_RD_DMA || cmd.opcode == OP_RD_DMA_EXT)
         |=> resp.proto == PROTO_DMA ##1 m_q.st == ST_BUSY;
   endproperty
   a_rd_dma: assert property (p_rd_dma) else $error("read DMA wrong");

   property p_wr_dma;
      take && cmd.opcode == OP_WR_DMA_FUA |=> resp.proto == PROTO_DMA;
   endproperty
   a_wr_dma: assert property (p_wr_dma) else $error("FUA write not DMA");

   property p_pio_in;
      take && (cmd.opcode == OP_RD_SECT_EXT || cmd.opcode == OP_RD_LOG_EXT)
         |=> resp.proto == PROTO_PIO_IN;
   endproperty
   a_pio_in: assert property (p_pio_in) else $error("sector read not PIO in");

   property p_pio_out;
      take && (cmd.opcode == OP_WR_SECT || cmd.opcode == OP_WR_MULT)
         |=> resp.proto == PROTO_PIO_OUT;
   endproperty
   a_pio_out: assert property (p_pio_out) else $error("sector write not PIO out");

   property p_health;
      take && cmd.opcode == OP_HEALTH && cmd.features == HM_WR_LOG
         |=> resp.proto == PROTO_PIO_OUT;
   endproperty
   a_health: assert property (p_health) else $error("log write not PIO out");

   property p_setmax;
      take && cmd.opcode == OP_SET_MAX && cmd.features == SM_FREEZE
         |=> resp.proto == PROTO_NONDATA;
   endproperty
   a_setmax: assert property (p_setmax) else $error("freeze lock not non-data");

   property p_abort;
      take && classify(cmd) == PROTO_ABORT |=> resp.error ##1 cmd_ready;
   endproperty
   a_abort: assert property (p_abort) else $error("abort entered data phase");

   property p_activity;
      m_q.strap_done && m_q.st == ST_BUSY |-> !activity_or_stagger_disable_oe_n;
   endproperty
   a_activity: assert property (p_activity) else $error("activity not shown");

   property p_strap;
      !m_q.strap_done |-> activity_or_stagger_disable_oe_n;
   endproperty
   a_strap: assert property (p_strap) else $error("pin driven during strap");

   property p_twi;
      twi_clk_oe_n && twi_data_oe_n && $stable(twi_clk_out);
   endproperty
   a_twi: assert property (p_twi) else $error("two-wire pin driven");

   property p_verify;
      take && (cmd.opcode == OP_VERIFY || cmd.opcode == OP_VERIFY_EXT)
         |=> resp.proto == PROTO_NONDATA && !resp.error;
   endproperty
   a_verify: assert property (p_verify) else $error("verify not non-data");

   property p_nop;
      take && (cmd.opcode == OP_NOP || cmd.opcode == OP_INIT_PARAMS)
         |=> resp.proto == PROTO_NONDATA;
   endproperty
   a_nop: assert property (p_nop) else $error("no-operation not non-data");

   property p_buffer;
      take && cmd.opcode == OP_RD_BUF |=> resp.proto == PROTO_PIO_IN;
   endproperty
   a_buffer: assert property (p_buffer) else $error("buffer read not PIO in");

   property p_dsm;
      take && cmd.opcode == OP_DSM |=> resp.proto == PROTO_PIO_OUT && !resp.error;
   endproperty
   a_dsm: assert property (p_dsm) else $error("set management not PIO out");

   property p_power;
      take && (cmd.opcode == OP_PWR_MODE_ALT || cmd.opcode == OP_IDLE_ALT)
         |=> resp.proto == PROTO_NONDATA;
   endproperty
   a_power: assert property (p_power) else $error("power query not non-data");

   property p_standby;
      take && (cmd.opcode == OP_SLEEP || cmd.opcode == OP_STBY_IMM_ALT)
         |=> resp.proto == PROTO_NONDATA;
   endproperty
   a_standby: assert property (p_standby) else $error("standby not non-data");

   property p_sec_out;
      take && (cmd.opcode == OP_SEC_UNLOCK || cmd.opcode == OP_SEC_DIS_PWD)
         |=> resp.proto == PROTO_PIO_OUT;
   endproperty
   a_sec_out: assert property (p_sec_out) else $error("security payload not PIO out");

   property p_sec_nd;
      take && cmd.opcode == OP_SEC_FREEZE |=> resp.proto == PROTO_NONDATA;
   endproperty
   a_sec_nd: assert property (p_sec_nd) else $error("freeze not non-data");

   property p_hm_read;
      take && cmd.opcode == OP_HEALTH && cmd.features == HM_RD_THRESH
         |=> resp.proto == PROTO_PIO_IN;
   endproperty
   a_hm_read: assert property (p_hm_read) else $error("threshold read not PIO in");

   property p_native;
      take && cmd.opcode == OP_RD_NATIVE_EXT |=> resp.proto == PROTO_NONDATA;
   endproperty
   a_native: assert property (p_native) else $error("native max not non-data");
endmodule

/* sim/acd_host_model.sv */
// Host controller model: completes commands and shares the open-drain sideband pin
`timescale 1ns/1ns
module acd_host_model
   import acd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Answer from the decoder and completion back
   input wire logic resp_valid,
   input wire acd_resp_t resp,
   output logic cmd_done,
   // Bench controls: strap level and completion lag
   input wire logic strap_low,
   input wire logic [2:0] lag,
   // Sideband pin, open drain with pull-up
   input wire logic dev_out,
   input wire logic dev_oe_n,
   output logic pin_level
);
   // Wired-AND of both parties, pull-up when nobody pulls low
   assign pin_level = (strap_low || (dev_oe_n === 1'b0 && dev_out === 1'b0)) ? 1'b0 : 1'b1;

   // Back end finishes every command answered without error, promptly or after a lag
   initial begin
      cmd_done = 1'b0;
      forever begin
         @(negedge clk);
         if (reset_n === 1'b1 && resp_valid === 1'b1 && resp.error === 1'b0) begin
            @(negedge clk);
            repeat (lag) @(negedge clk);
            cmd_done = 1'b1;
            @(negedge clk);
            cmd_done = 1'b0;
         end
      end
   end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the storage command decoder
`timescale 1ns/1ns
module testbench;
   import acd_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cmd_valid = 1'b0;
   acd_cmd_t cmd = 16'h0000;
   logic cmd_ready, resp_valid, cmd_done, pin_level, dss_out, dss_oe_n, stag_dis;
   logic sleep_in = 1'b1;
   logic sleep_req, twc_o, twc_oe_n, twd_o, twd_oe_n;
   logic strap_low = 1'b1;
   logic [2:0] lag = 3'h0;
   acd_resp_t resp;
   acd_resp_t exp_q[$];
   int error_cnt = 0;
   int n_tests = 0;
   int seed = 63;

   // 100 MHz clock
   always #5 clk = ~clk;

   acd_decoder acd_decoder_i (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp(resp), .cmd_done(cmd_done),
      .activity_or_stagger_disable_in(pin_level), .activity_or_stagger_disable_out(dss_out),
      .activity_or_stagger_disable_oe_n(dss_oe_n), .stagger_disable(stag_dis),
      .deep_sleep_request_in(sleep_in), .deep_sleep_request(sleep_req),
      .twi_clk_out(twc_o), .twi_clk_oe_n(twc_oe_n), .twi_data_out(twd_o),
      .twi_data_oe_n(twd_oe_n));

   acd_host_model acd_host_model_i (.clk(clk), .reset_n(reset_n), .resp_valid(resp_valid),
      .resp(resp), .cmd_done(cmd_done), .strap_low(strap_low), .lag(lag), .dev_out(dss_out),
      .dev_oe_n(dss_oe_n), .pin_level(pin_level));

   // Verdict and end of run
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Single comparison point
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Expected transfer class of an opcode and its features byte
   function automatic acd_proto_t exp_p(input logic [7:0] op, input logic [7:0] f);
      case (op)
         8'h90: return PROTO_DIAG;
         8'hE7, 8'hEA, 8'h40, 8'h41, 8'h42, 8'hEF, 8'hC6, 8'h91, 8'h00,
         8'hE5, 8'h98, 8'hE3, 8'h97, 8'hE1, 8'h95, 8'hE6, 8'h99,
         8'hE2, 8'h96, 8'hE0, 8'h94, 8'hF3, 8'hF5, 8'hF8, 8'h27, 8'h37:
            return PROTO_NONDATA;
         8'hEC, 8'h20, 8'h21, 8'h24, 8'hC4, 8'h2F, 8'hE4: return PROTO_PIO_IN;
         8'h30, 8'h31, 8'h34, 8'hC5, 8'h3F, 8'hE8, 8'h06, 8'h92,
         8'hF1, 8'hF2, 8'hF4, 8'hF6: return PROTO_PIO_OUT;
         8'hC8, 8'h25, 8'hCA, 8'h35, 8'h3D: return PROTO_DMA;
         8'hB0: begin
            case (f)
               8'hD0, 8'hD1, 8'hD5: return PROTO_PIO_IN;
               8'hD6: return PROTO_PIO_OUT;
               8'hD2, 8'hD3, 8'hD4, 8'hD8, 8'hD9, 8'hDA: return PROTO_NONDATA;
               default: return PROTO_ABORT;
            endcase
         end
         8'hF9: begin
            case (f)
               8'h00, 8'h02, 8'h04: return PROTO_NONDATA;
               8'h01, 8'h03: return PROTO_PIO_OUT;
               default: return PROTO_ABORT;
            endcase
         end
         default: return PROTO_ABORT;
      endcase
   endfunction

   // One command request, entered and left at a falling edge
   task automatic issue(input logic [7:0] op, input logic [7:0] f);
      acd_proto_t p;
      int n;
      p = exp_p(op, f);
      n = 0;
      cmd_valid = 1'b1;
      cmd = {op, f};
      while (cmd_ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) chk(16'(n), 16'h0000, "take_wait");
      exp_q.push_back(acd_resp_t'({p, op, p == PROTO_ABORT}));
      lag = 3'($random(seed));
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd = ~cmd;
      chk(16'(cmd_ready), 16'h0000, "ready_after_take");
      @(negedge clk);
      if (p == PROTO_ABORT) begin
         chk(16'(cmd_ready), 16'h0001, "ready_after_abort");
      end else begin
         chk(16'(cmd_ready), 16'h0000, "ready_while_busy");
         chk(16'(dss_oe_n), 16'h0000, "activity_busy");
      end
   endtask

   // Wait for the decoder to be free again
   task automatic wait_ready();
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200) chk(16'(n), 16'h0000, "ready_wait");
   endtask

   // Answer monitor: oldest note against each pulse
   always @(negedge clk) begin
      if (resp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(16'(resp), 16'hFFFF, "unexpected_resp");
         end else begin
            chk(16'(resp), 16'(exp_q.pop_front()), "resp");
         end
      end
   end

   // Watchdog against a hang
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      repeat (8) @(negedge clk);
      strap_low = 1'b0;
      repeat (3) @(negedge clk);
      chk(16'(stag_dis), 16'h0001, "stagger_low_strap");
      for (int i = 0; i < 256; i++) issue(8'(i), 8'($random(seed)));
      for (int f = 8'hCF; f <= 8'hDB; f++) issue(8'hB0, 8'(f));
      for (int f = 8'h00; f <= 8'h05; f++) issue(8'hF9, 8'(f));
      issue(8'hE7, 8'h00);
      wait_ready();
      repeat (4800) @(negedge clk);
      chk(16'(dss_oe_n), 16'h0000, "activity_hold");
      repeat (400) @(negedge clk);
      chk(16'(dss_oe_n), 16'h0001, "activity_end");
      chk(16'(pin_level), 16'h0001, "pin_idle");
      sleep_in = 1'b0;
      repeat (3) @(negedge clk);
      chk(16'(sleep_req), 16'h0001, "sleep_on");
      sleep_in = 1'b1;
      repeat (3) @(negedge clk);
      chk(16'(sleep_req), 16'h0000, "sleep_off");
      reset_n = 1'b0;
      @(negedge clk);
      chk(16'({cmd_ready, resp_valid, dss_oe_n}), 16'h0005, "reset_outputs");
      chk(16'(stag_dis), 16'h0000, "stagger_reset");
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (8) @(negedge clk);
      chk(16'(stag_dis), 16'h0000, "stagger_high_strap");
      issue(8'hEC, 8'h00);
      wait_ready();
      chk(16'({twc_o, twc_oe_n, twd_o, twd_oe_n}), 16'h0005, "two_wire_idle");
      chk(16'(exp_q.size()), 16'h0000, "pending_answers");
      tally_and_finish();
   end
endmodule
